// File: hdl/rcs_params.svh
// constants of the reader command sequencer: codes, sizes, timing
// assumes one 200 MHz clock shared by both ends
//
// Function
// R01 - written command code starts that command
// R02 - arguments and data travel through the fifo
// R03 - stream commands consume fifo bytes at once
// R04 - argument commands wait for full argument count
// R05 - fifo is not flushed at command start
// R06 - new code aborts any running command; the code leaves init running and ignores a written 3Fh
// R07 - code 3Fh runs reset and initialisation
// R08 - init only by reset, never by host
// R09 - code 00h idles and cancels current command
// R10 - code 1Ah sends fifo stream to card
// R11 - code 16h waits delay, then receives
// R12 - host uses standalone receive for test only
// R13 - finished command returns register to idle
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

`define RCS_CMD_IDLE     8'h00
`define RCS_CMD_TRANSMIT 8'h1A
`define RCS_CMD_RECEIVE  8'h16
`define RCS_CMD_POWERUP  8'h3F

`define RCS_FIFO_DEPTH   64
`define RCS_PTR_W        6
`define RCS_LVL_W        7

`define RCS_CLK_PERIOD_PS 5000
`define RCS_INIT_TIME_NS  160
`define RCS_INIT_CYCLES \
   ((`RCS_INIT_TIME_NS * 1000 + `RCS_CLK_PERIOD_PS - 1) / `RCS_CLK_PERIOD_PS)
`define RCS_INIT_CNT_W    8

`endif

// File: hdl/rcs_pkg.sv
// types of the reader command sequencer
// assumes rcs_params.svh is on the include path
`include "rcs_params.svh"

package rcs_pkg;

   typedef enum logic [4:0] {
      ST_INIT = 5'h01,
      ST_IDLE = 5'h02,
      ST_TX   = 5'h04,
      ST_WAIT = 5'h08,
      ST_RX   = 5'h10
   } rcs_state_t;

   typedef struct packed {
      rcs_state_t                 state;
      logic [7:0]                 cmd;
      logic [`RCS_PTR_W-1:0]      wr_ptr;
      logic [`RCS_PTR_W-1:0]      rd_ptr;
      logic [`RCS_LVL_W-1:0]      level;
      logic [7:0]                 wait_cnt;
      logic [`RCS_INIT_CNT_W-1:0] init_cnt;
      logic [7:0]                 tx_data;
      logic                       tx_valid;
      logic [7:0]                 rd_data;
      logic                       rx_en;
   } rcs_dev_t;

   typedef struct packed {
      logic       cmd_wr;
      logic [7:0] cmd_code;
      logic       busy;
      logic       done;
      logic       wr_valid;
      logic [7:0] wr_data;
      logic       un_valid;
   } rcs_host_t;

endpackage : rcs_pkg

// File: hdl/rcs_if.sv
// link between host and sequencer: command port and fifo access
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "rcs_params.svh"

interface rcs_if;
   logic                  cmd_wr;     // one-cycle command write
   logic [7:0]            cmd_code;
   logic [7:0]            cmd_cur;    // command register readback
   logic                  wr_valid;   // host push into fifo
   logic [7:0]            wr_data;
   logic                  wr_ready;
   logic                  rd_valid;   // host pop from fifo
   logic [7:0]            rd_data;
   logic                  rd_ready;
   logic [`RCS_LVL_W-1:0] level;

   modport dev (input cmd_wr, cmd_code, wr_valid, wr_data, rd_ready,
                output cmd_cur, wr_ready, rd_valid, rd_data, level);
   modport host (output cmd_wr, cmd_code, wr_valid, wr_data, rd_ready,
                 input cmd_cur, wr_ready, rd_valid, rd_data, level);
endinterface : rcs_if

`default_nettype wire

// File: hdl/rcs_device.sv
// command sequencer of the reader, with its 64-byte fifo
// assumes a host on rcs_if.dev, a radio transmitter taking bytes
// on TX_*, and a receiver delivering bytes on RX_*
`timescale 1ns/1ps
`default_nettype none
`include "rcs_params.svh"

module rcs_device (
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   rcs_if.dev               LINK,
   input  wire logic [7:0]  RX_WAIT,
   output logic      [7:0]  TX_DATA,
   output logic             TX_VALID,
   input  wire logic        TX_READY,
   output logic             RX_ENABLE,
   input  wire logic [7:0]  RX_DATA,
   input  wire logic        RX_VALID,
   output logic             RX_READY,
   input  wire logic        RX_DONE,
   output logic             INIT_ACTIVE
);

   ////////////////////////////////////////////////////////////////////
   // state and storage

   rcs_pkg::rcs_dev_t r_ff;
   rcs_pkg::rcs_dev_t nxt_r;
   logic [7:0]        mem [`RCS_FIFO_DEPTH];

   logic push;
   logic pop;
   logic host_push;
   logic rx_push;
   logic host_pop;
   logic tx_pop;
   logic empty;
   logic full;

   // next state for a code written by the host
   function automatic rcs_pkg::rcs_state_t code_state(input logic [7:0] c);
      // none of these codes takes argument bytes, so none waits on them
      if (c == `RCS_CMD_TRANSMIT) begin // see R04
         return rcs_pkg::ST_TX; // see R10
      end else if (c == `RCS_CMD_RECEIVE) begin
         return rcs_pkg::ST_WAIT; // see R11
      end else begin
         return rcs_pkg::ST_IDLE; // see R09
      end
   endfunction : code_state

   ////////////////////////////////////////////////////////////////////
   // fifo port arbitration

   // one push source and one pop source per state keeps the fifo single
   // ported; host pops are held off while transmit owns the read side
   always_comb begin
      empty     = (r_ff.level == '0);
      full      = (r_ff.level == `RCS_LVL_W'(`RCS_FIFO_DEPTH));
      RX_READY  = r_ff.rx_en && !full;
      rx_push   = RX_READY && RX_VALID; // see R11
      host_push = LINK.wr_valid && LINK.wr_ready; // see R02
      push      = host_push || rx_push;
      tx_pop    = (r_ff.state == rcs_pkg::ST_TX) && !empty
                  && (!r_ff.tx_valid || TX_READY);
      host_pop  = LINK.rd_valid && LINK.rd_ready;
      pop       = tx_pop || host_pop;
   end

   // host handshake: push refused during init and receive, pop refused during init and transmit
   always_comb begin
      LINK.wr_ready = !full && (r_ff.state == rcs_pkg::ST_IDLE
                      || r_ff.state == rcs_pkg::ST_TX);
      LINK.rd_valid = !empty && (r_ff.state == rcs_pkg::ST_IDLE
                      || r_ff.state == rcs_pkg::ST_WAIT
                      || r_ff.state == rcs_pkg::ST_RX);
   end

   ////////////////////////////////////////////////////////////////////
   // sequencer

   always_comb begin
      nxt_r = r_ff;
      // pointers and level
      if (push) begin
         nxt_r.wr_ptr = r_ff.wr_ptr + `RCS_PTR_W'(1);
      end
      if (pop) begin
         nxt_r.rd_ptr = r_ff.rd_ptr + `RCS_PTR_W'(1);
      end
      // only host pops load the read byte, so a waiting byte survives transmit
      if (host_pop) begin
         nxt_r.rd_data = mem[r_ff.rd_ptr]; // see R02
      end
      if (push && !pop) begin
         nxt_r.level = r_ff.level + `RCS_LVL_W'(1);
      end else if (pop && !push) begin
         nxt_r.level = r_ff.level - `RCS_LVL_W'(1);
      end
      // transmit output stage
      if (r_ff.tx_valid && TX_READY) begin
         nxt_r.tx_valid = 1'b0;
      end
      if (tx_pop) begin
         nxt_r.tx_data  = mem[r_ff.rd_ptr]; // see R03
         nxt_r.tx_valid = 1'b1;
      end

      case (r_ff.state)
         rcs_pkg::ST_INIT: begin
            // host writes are not looked at here
            nxt_r.cmd = `RCS_CMD_POWERUP; // see R07 see R08
            if (r_ff.init_cnt == '0) begin
               nxt_r.state = rcs_pkg::ST_IDLE;
               nxt_r.cmd   = `RCS_CMD_IDLE; // see R13
            end else begin
               nxt_r.init_cnt = r_ff.init_cnt - `RCS_INIT_CNT_W'(1);
            end
         end
         rcs_pkg::ST_TX: begin
            // ends once fifo and output stage have both drained
            if (empty && !r_ff.tx_valid) begin
               nxt_r.state = rcs_pkg::ST_IDLE;
               nxt_r.cmd   = `RCS_CMD_IDLE; // see R13
            end
         end
         rcs_pkg::ST_WAIT: begin
            if (r_ff.wait_cnt == '0) begin
               nxt_r.state = rcs_pkg::ST_RX;
               nxt_r.rx_en = 1'b1; // see R11
            end else begin
               nxt_r.wait_cnt = r_ff.wait_cnt - 8'h01;
            end
         end
         rcs_pkg::ST_RX: begin
            if (RX_DONE) begin
               nxt_r.state = rcs_pkg::ST_IDLE;
               nxt_r.cmd   = `RCS_CMD_IDLE; // see R13
               nxt_r.rx_en = 1'b0;
            end
         end
         default: begin
            nxt_r.state = rcs_pkg::ST_IDLE;
         end
      endcase

      // a host write other than 3Fh aborts anything but init and starts the new code
      if (LINK.cmd_wr && r_ff.state != rcs_pkg::ST_INIT
          && LINK.cmd_code != `RCS_CMD_POWERUP) begin // see R06 see R08
         nxt_r.state    = code_state(LINK.cmd_code); // see R01
         nxt_r.rx_en    = 1'b0;
         nxt_r.tx_valid = 1'b0; // pending byte dropped on abort
         nxt_r.wait_cnt = RX_WAIT; // see R11
         if (code_state(LINK.cmd_code) == rcs_pkg::ST_IDLE) begin
            nxt_r.cmd = `RCS_CMD_IDLE; // see R09 see R13
         end else begin
            nxt_r.cmd = LINK.cmd_code; // see R01
         end
         // pointers untouched: preloaded bytes survive the start
      end // see R05
   end

   // registered copy; reset enters init, never a host write
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         r_ff          <= '0;
         r_ff.state    <= rcs_pkg::ST_INIT; // see R08
         r_ff.cmd      <= `RCS_CMD_POWERUP;
         r_ff.init_cnt <= `RCS_INIT_CNT_W'(`RCS_INIT_CYCLES - 1);
      end else begin
         r_ff <= nxt_r;
      end
   end

   // fifo storage, no reset needed: level guards every read
   always_ff @(posedge CLOCK) begin
      if (push) begin
         mem[r_ff.wr_ptr] <= host_push ? LINK.wr_data : RX_DATA;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   always_comb begin
      LINK.cmd_cur = r_ff.cmd; // see R13
      LINK.rd_data = r_ff.rd_data;
      LINK.level   = r_ff.level;
      TX_DATA      = r_ff.tx_data;
      TX_VALID     = r_ff.tx_valid; // see R10
      RX_ENABLE    = r_ff.rx_en;
      INIT_ACTIVE  = (r_ff.state == rcs_pkg::ST_INIT);
   end

endmodule : rcs_device

`default_nettype wire

// File: hdl/rcs_host.sv
// host end: issues command codes and moves bytes through the fifo
// assumes the sequencer on the other side of rcs_if
`timescale 1ns/1ps
`default_nettype none
`include "rcs_params.svh"

module rcs_host (
   input  wire logic                  CLOCK,
   input  wire logic                  RST_N,
   rcs_if.host                        LINK,
   input  wire logic                  CMD_START,
   input  wire logic [7:0]            CMD_CODE,
   input  wire logic                  TEST_MODE,
   output logic                       CMD_READY,
   output logic                       BUSY,
   output logic                       DONE,
   input  wire logic                  LOAD_VALID,
   input  wire logic [7:0]            LOAD_DATA,
   output logic                       LOAD_READY,
   output logic                       UNLOAD_VALID,
   output logic      [7:0]            UNLOAD_DATA,
   input  wire logic                  UNLOAD_READY,
   output logic      [`RCS_LVL_W-1:0] LEVEL
);

   rcs_pkg::rcs_host_t h_ff;
   rcs_pkg::rcs_host_t nxt_h;
   logic               allowed;

   ////////////////////////////////////////////////////////////////////
   // command issue and completion tracking

   always_comb begin
      // receive alone has no timing tie to transmit: test mode only
      allowed    = (CMD_CODE != `RCS_CMD_RECEIVE) || TEST_MODE; // see R12
      // a new code may be written while busy, to abort
      CMD_READY  = (LINK.cmd_cur != `RCS_CMD_POWERUP) && !h_ff.cmd_wr;
      LOAD_READY = !h_ff.wr_valid || LINK.wr_ready;
      // pop on demand only: a prefetch would steal preloaded bytes
      LINK.rd_ready = UNLOAD_READY; // see R05
   end

   always_comb begin
      nxt_h        = h_ff;
      nxt_h.cmd_wr = 1'b0;
      nxt_h.done   = 1'b0;
      if (CMD_START && CMD_READY && allowed) begin
         nxt_h.cmd_wr   = 1'b1; // see R01 see R06
         nxt_h.cmd_code = CMD_CODE;
         nxt_h.busy     = (CMD_CODE != `RCS_CMD_IDLE);
      end else if (h_ff.busy && !h_ff.cmd_wr
                   && LINK.cmd_cur == `RCS_CMD_IDLE) begin
         nxt_h.busy = 1'b0; // see R13
         nxt_h.done = 1'b1;
      end
      // load stage into the fifo, usable before the command
      if (LINK.wr_ready) begin
         nxt_h.wr_valid = 1'b0;
      end
      if (LOAD_VALID && LOAD_READY) begin
         nxt_h.wr_valid = 1'b1; // see R02 see R05
         nxt_h.wr_data  = LOAD_DATA;
      end
      // unload stage; fifo data shows one cycle after the pop
      if (UNLOAD_READY) begin
         nxt_h.un_valid = 1'b0;
      end
      if (LINK.rd_valid && LINK.rd_ready) begin
         nxt_h.un_valid = 1'b1;
      end
   end

   // registered copy of the host state
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         h_ff <= '0;
      end else begin
         h_ff <= nxt_h;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   always_comb begin
      LINK.cmd_wr   = h_ff.cmd_wr;
      LINK.cmd_code = h_ff.cmd_code;
      LINK.wr_valid = h_ff.wr_valid;
      LINK.wr_data  = h_ff.wr_data;
      BUSY          = h_ff.busy;
      DONE          = h_ff.done;
      UNLOAD_VALID  = h_ff.un_valid;
      UNLOAD_DATA   = LINK.rd_data; // sequencer register, held until the next pop
      LEVEL         = LINK.level;
   end

endmodule : rcs_host

`default_nettype wire

// File: verification/rcs_chk_chk.sv
// checker of the host-sequencer link: command register and fifo level
// assumes one clock and a synchronous active-low reset for both ends
`timescale 1ns/1ps
`default_nettype none
`include "rcs_params.svh"

module rcs_chk (
   input wire logic                  CLOCK,
   input wire logic                  RST_N,
   input wire logic                  cmd_wr,
   input wire logic [7:0]            cmd_code,
   input wire logic [7:0]            cmd_cur,
   input wire logic                  wr_valid,
   input wire logic [7:0]            wr_data,
   input wire logic                  wr_ready,
   input wire logic                  rd_valid,
   input wire logic [7:0]            rd_data,
   input wire logic                  rd_ready,
   input wire logic [`RCS_LVL_W-1:0] level
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////////////
   // transmit starting with bytes waiting, then the fifo must shrink
   sequence tx_start_s;
      $rose(cmd_cur == 8'h1A) && level != '0;
   endsequence
   sequence level_drop_s;
      ##[1:16] level < $past(level);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   // command register and fifo access around init and commands
   chk_reset_init: assert property ($rose(RST_N) |-> cmd_cur == 8'h3F)
      else $error("init not entered after reset");
   chk_init_closed: assert property (cmd_cur == 8'h3F |-> !wr_ready && !rd_valid)
      else $error("fifo open during init");
   chk_init_locked: assert property (cmd_wr && cmd_code == 8'h3F |=> cmd_cur != 8'h3F)
      else $error("host write started init");
   chk_code_taken: assert property (cmd_wr && cmd_code inside {8'h00, 8'h1A, 8'h16}
      |=> cmd_cur == $past(cmd_code))
      else $error("written code not taken");
   // a running transmit may pop in the same cycle, so it is left out
   chk_no_flush: assert property (cmd_wr && !(rd_valid && rd_ready) && cmd_cur != 8'h1A
      |=> level >= $past(level))
      else $error("fifo flushed at command start");
   chk_tx_consumes: assert property (tx_start_s |-> level_drop_s)
      else $error("transmit did not consume fifo");
   chk_tx_no_unload: assert property (cmd_cur == 8'h1A |-> !rd_valid)
      else $error("host pop offered during transmit");
   chk_tx_returns: assert property (cmd_cur == 8'h1A && level == '0
      |-> ##[1:8] cmd_cur != 8'h1A)
      else $error("transmit did not return to idle");
   chk_rx_no_load: assert property (cmd_cur == 8'h16 |-> !wr_ready)
      else $error("host push accepted during receive");
   chk_push_counts: assert property (wr_valid && wr_ready && !(rd_valid && rd_ready)
      && cmd_cur == 8'h00 |=> level == $past(level) + 7'h01)
      else $error("host push not counted in fifo");
   chk_read_held: assert property (!(rd_valid && rd_ready) |=> $stable(rd_data))
      else $error("read byte changed without a pop");
endmodule : rcs_chk

`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench: host end and sequencer joined by rcs_if
// assumes a 200 MHz clock and radio side driven by the bench
`timescale 1ns/1ps
`default_nettype none
`include "rcs_params.svh"

module tb_top;
   logic                  CLOCK, RST_N, CMD_START, TEST_MODE, LOAD_VALID, UNLOAD_READY;
   logic                  TX_READY, RX_VALID, RX_DONE, CMD_READY, BUSY, DONE, LOAD_READY;
   logic                  UNLOAD_VALID, TX_VALID, RX_ENABLE, RX_READY, INIT_ACTIVE;
   logic [7:0]            CMD_CODE, LOAD_DATA, RX_WAIT, RX_DATA, UNLOAD_DATA, TX_DATA;
   logic [`RCS_LVL_W-1:0] LEVEL;
   int                    error_cnt, compares, n, lv;
   logic [7:0]            txq[$];
   logic [7:0]            pat[8] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5, 8'hF6, 8'h07, 8'h18};

   rcs_if lnk ();
   rcs_device rcs_device_i (.CLOCK, .RST_N, .LINK(lnk), .RX_WAIT, .TX_DATA, .TX_VALID,
      .TX_READY, .RX_ENABLE, .RX_DATA, .RX_VALID, .RX_READY, .RX_DONE, .INIT_ACTIVE);
   rcs_host rcs_host_i (.CLOCK, .RST_N, .LINK(lnk), .CMD_START, .CMD_CODE, .TEST_MODE,
      .CMD_READY, .BUSY, .DONE, .LOAD_VALID, .LOAD_DATA, .LOAD_READY, .UNLOAD_VALID,
      .UNLOAD_DATA, .UNLOAD_READY, .LEVEL);
   rcs_chk rcs_chk_i (.CLOCK, .RST_N, .cmd_wr(lnk.cmd_wr), .cmd_code(lnk.cmd_code),
      .cmd_cur(lnk.cmd_cur), .wr_valid(lnk.wr_valid), .wr_data(lnk.wr_data),
      .wr_ready(lnk.wr_ready), .rd_valid(lnk.rd_valid), .rd_data(lnk.rd_data),
      .rd_ready(lnk.rd_ready), .level(lnk.level));
   ////////////////////////////////////////////////////////////////////////////////
   // clock, and a record of every byte the radio side accepts
   initial begin
      CLOCK = 1'b0;
      forever #2.5 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) begin
      if (RST_N === 1'b1 && TX_VALID === 1'b1 && TX_READY === 1'b1) txq.push_back(TX_DATA);
   end
   ////////////////////////////////////////////////////////////////////////////////
   // helpers; load and unload leave their strobes high so back-to-back calls never toggle them, cmd drops CMD_START after one cycle
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge CLOCK);
      #1;
   endtask : cyc
   task automatic cmd(input logic [7:0] c);
      n = 0;
      while (CMD_READY !== 1'b1 && n < 200) begin cyc(1); n++; end
      chk(CMD_READY, 1'b1);
      CMD_START = 1'b1;
      CMD_CODE  = c;
      cyc(1);
      CMD_START = 1'b0;
   endtask : cmd
   task automatic load(input logic [7:0] b);
      LOAD_VALID = 1'b1;
      LOAD_DATA  = b;
      n = 0;
      while (LOAD_READY !== 1'b1 && n < 200) begin cyc(1); n++; end
      chk(LOAD_READY, 1'b1);
      cyc(1);
   endtask : load
   task automatic unload(input logic [7:0] e);
      UNLOAD_READY = 1'b1;
      n = 0;
      while (UNLOAD_VALID !== 1'b1 && n < 200) begin cyc(1); n++; end
      chk(UNLOAD_VALID, 1'b1);
      chk(UNLOAD_DATA, e);
      cyc(1);
   endtask : unload
   task automatic end_of_test;
      $display("error_cnt %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////////////
   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      #20000;
      error_cnt++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {CMD_START, TEST_MODE, LOAD_VALID, UNLOAD_READY, RX_VALID, RX_DONE} = '0;
      {CMD_CODE, LOAD_DATA, RX_DATA} = '0;
      RX_WAIT  = 8'h05;
      TX_READY = 1'b1;
      RST_N    = 1'b0;
      repeat (10) @(posedge CLOCK);
      #1 RST_N = 1'b1;
      cyc(1);
      chk(lnk.cmd_cur, 8'h3F);
      chk(INIT_ACTIVE, 1'b1);
      // host write of the init code is ignored
      cmd(8'h3F);
      cyc(4);
      chk(lnk.cmd_cur, 8'h00);
      chk(INIT_ACTIVE, 1'b0);
      // preloaded bytes survive the start and go out in order
      for (int i = 0; i < 3; i++) load(pat[i]);
      LOAD_VALID = 1'b0;
      cyc(2);
      chk(LEVEL, 8'h03);
      cmd(8'h1A);
      chk(BUSY, 1'b1);
      n = 0;
      while (DONE !== 1'b1 && n < 100) begin cyc(1); n++; end
      chk(DONE, 1'b1);
      chk(BUSY, 1'b0);
      chk(txq.size(), 8'h03);
      for (int i = 0; i < 3; i++) chk(txq[i], pat[i]);
      chk(lnk.cmd_cur, 8'h00);
      // idle aborts a long transmit; the rest stays in the fifo
      txq.delete();
      for (int i = 0; i < 8; i++) load(pat[i]);
      LOAD_VALID = 1'b0;
      cmd(8'h1A);
      cmd(8'h00);
      cyc(2);
      lv = LEVEL;
      cyc(5);
      chk(LEVEL, lv[7:0]);
      chk(lnk.cmd_cur, 8'h00);
      chk(txq.size() < 8, 1'b1);
      for (int i = 0; i < txq.size(); i++) chk(txq[i], pat[i]);
      UNLOAD_READY = 1'b1;
      n = 0;
      while (LEVEL !== '0 && n < 100) begin cyc(1); n++; end
      cyc(3);
      UNLOAD_READY = 1'b0;
      chk(LEVEL, 8'h00);
      // receive in test mode: enable after the delay, bytes into the fifo
      TEST_MODE = 1'b1;
      cmd(8'h16);
      n = 0;
      while (RX_ENABLE !== 1'b1 && n < 50) begin cyc(1); n++; end
      chk(n[7:0], RX_WAIT + 8'h02);
      chk(RX_READY, 1'b1);
      RX_DATA  = 8'h5A;
      RX_VALID = 1'b1;
      cyc(1);
      RX_DATA  = 8'h6B;
      cyc(1);
      RX_VALID = 1'b0;
      RX_DONE  = 1'b1;
      cyc(1);
      RX_DONE  = 1'b0;
      cyc(1);
      chk(lnk.cmd_cur, 8'h00);
      chk(RX_ENABLE, 1'b0);
      unload(8'h5A);
      unload(8'h6B);
      UNLOAD_READY = 1'b0;
      // standalone receive is refused outside test mode
      TEST_MODE = 1'b0;
      cmd(8'h16);
      cyc(4);
      chk(lnk.cmd_cur, 8'h00);
      chk(RX_ENABLE, 1'b0);
      // a second reset mid-run re-enters init, which then ends by itself
      RST_N = 1'b0;
      cyc(2);
      RST_N = 1'b1;
      cyc(1);
      chk(lnk.cmd_cur, 8'h3F);
      chk(INIT_ACTIVE, 1'b1);
      cyc(33);
      chk(lnk.cmd_cur, 8'h00);
      end_of_test();
   end
endmodule : tb_top

`default_nettype wire
